/* File: design/pgt_top.v */
// output-ok sequencing, telemetry latching and serial slave of the power module
`timescale 1ns/1ps
`include "pgt_defines.vh"
module pgt_top #(
	parameter TEMP_CONV_CYCLES = `PGT_TEMP_CONV_CYCLES,
	parameter SS_BASE_CYCLES = `PGT_SS_BASE_CYCLES
) (
	// clock and reset
	input wire clk_sys_in,
	input wire sys_rst_in,
	// power status
	input wire remote_enable_in,
	input wire input_lockout_upper_threshold_in,
	input wire fault_in,
	input wire [7:0] vout_meas_in,
	// adc results
	input wire adc_valid_in,
	input wire [1:0] adc_chan_in,
	input wire [15:0] adc_data_in,
	// serial bus pins
	input wire scl_in,
	input wire sda_in,
	output wire sda_oe_out,
	output wire sda_out,
	// output-ok open drain pin
	output wire output_ok_flag_out,
	output wire output_ok_flag_oe_out,
	// soft start progress and temperature conversion start
	output reg soft_start_done_out,
	output reg temp_conv_start_out
);
	localparam ST_OFF = 3'b001;
	localparam ST_NG = 3'b010;
	localparam ST_OK = 3'b100;
	localparam BS_IDLE = 4'b0001;
	localparam BS_ADDR = 4'b0010;
	localparam BS_DATA = 4'b0100;
	localparam BS_ACK = 4'b1000;

	reg [7:0] vset;
	reg [7:0] config_reg;
	reg [15:0] hold [0:3];
	reg [15:0] vis [0:3];
	reg [2:0] st;
	reg [2:0] next_st;
	reg [31:0] ss_cnt;
	reg [31:0] tcnt;
	reg scl_d;
	reg sda_d;
	reg [3:0] bs;
	reg [3:0] bitn;
	reg [7:0] shreg;
	reg rw;
	reg [1:0] bytei;
	reg [7:0] regaddr;
	reg [7:0] txbyte;
	reg sda_drive;
	reg pend_wr;
	reg [7:0] wdata;
	wire active;
	wire in5;
	wire in10;
	wire scl_rise;
	wire scl_fall;
	wire start_c;
	wire stop_c;
	reg [7:0] rd_mux;
	wire [7:0] sent_addr;
	wire copy_now;
	wire [31:0] ss_limit;
	wire tconv_wrap;
	// widths fixed here so the shift and compare stay 32 bits
	localparam [31:0] SS_BASE = SS_BASE_CYCLES;
	localparam [31:0] TCONV_LAST = TEMP_CONV_CYCLES - 1;

	assign active = remote_enable_in & input_lockout_upper_threshold_in;
	pgt_window #(.W(8), .PCT(5)) u_win5 (.target_in(vset), .value_in(vout_meas_in), .inside_out(in5));
	pgt_window #(.W(8), .PCT(10)) u_win10 (.target_in(vset), .value_in(vout_meas_in), .inside_out(in10));
	// the address counter has already stepped past the byte on the wire
	assign sent_addr = regaddr - 8'h01;
	assign copy_now = (bs == BS_DATA) && rw && scl_fall && (bitn == 4'h8);
	assign ss_limit = SS_BASE << config_reg[`PGT_SS_MSB:`PGT_SS_LSB];
	assign tconv_wrap = (tcnt >= TCONV_LAST);

	// ramp duration doubles with each code, i.e. rate halves
	always @(posedge clk_sys_in) begin
		if (sys_rst_in || !active) begin
			ss_cnt <= 32'h0;
			soft_start_done_out <= 1'b0;
		end else if (!soft_start_done_out) begin
			// counter stops once done, so a long enable never wraps it
			if (ss_cnt >= ss_limit)
				soft_start_done_out <= 1'b1;
			else
				ss_cnt <= ss_cnt + 32'h1;
		end
	end

	always @* begin
		next_st = st;
		case (st)
			ST_OFF: if (active) next_st = ST_NG;
			ST_NG: if (soft_start_done_out && !fault_in && in5) next_st = ST_OK;
			// fault wins over regulation so a trip always pulls the flag while active
			ST_OK: if (fault_in || !in10) next_st = ST_NG;
			default: next_st = ST_OFF;
		endcase
		if (!active)
			next_st = ST_OFF;
	end

	always @(posedge clk_sys_in) begin
		if (sys_rst_in)
			st <= ST_OFF;
		else
			st <= next_st;
	end

	// open drain: enable pulls low only while not good; off state releases
	assign output_ok_flag_out = 1'b0;
	assign output_ok_flag_oe_out = (st == ST_NG);

	// temperature conversion pacing
	// free-running pace keeps only one conversion in flight at a time
	always @(posedge clk_sys_in) begin
		if (sys_rst_in || tconv_wrap) begin
			tcnt <= 32'h0;
			temp_conv_start_out <= !sys_rst_in;
		end else begin
			tcnt <= tcnt + 32'h1;
			temp_conv_start_out <= 1'b0;
		end
	end

	// channel 0 vout, 1 vin, 2 iout, 3 temperature in half-degree steps
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_tel
			always @(posedge clk_sys_in) begin
				if (sys_rst_in) begin
					hold[g] <= 16'h0000;
					vis[g] <= 16'h0000;
				end else begin
					if (adc_valid_in && adc_chan_in == g)
						hold[g] <= adc_data_in;
					// copy once the upper byte has left; lower reads leave pair alone
					if (copy_now && rd_sel_upper(sent_addr) == g + 1)
						vis[g] <= hold[g];
				end
			end
		end
	endgenerate

	function [2:0] rd_sel_upper;
		input [7:0] a;
		begin
			case (a)
				`PGT_REG_VOUT_MSB: rd_sel_upper = 3'd1;
				`PGT_REG_VIN: rd_sel_upper = 3'd2;
				`PGT_REG_IOUT: rd_sel_upper = 3'd3;
				`PGT_REG_TEMP_MSB: rd_sel_upper = 3'd4;
				default: rd_sel_upper = 3'd0;
			endcase
		end
	endfunction

	// single-byte registers read their upper byte, so each read refreshes
	always @* begin
		case (regaddr)
			`PGT_REG_VSET: rd_mux = vset;
			`PGT_REG_CONFIG: rd_mux = config_reg;
			`PGT_REG_VOUT_LSB: rd_mux = vis[0][7:0];
			`PGT_REG_VOUT_MSB: rd_mux = vis[0][15:8];
			`PGT_REG_VIN: rd_mux = vis[1][15:8];
			`PGT_REG_IOUT: rd_mux = vis[2][15:8];
			`PGT_REG_TEMP_LSB: rd_mux = vis[3][7:0];
			`PGT_REG_TEMP_MSB: rd_mux = vis[3][15:8];
			default: rd_mux = `PGT_UNMAPPED;
		endcase
	end

	// pins are sampled with no glitch filter, so slow edges must be clean
	assign scl_rise = scl_in & ~scl_d;
	assign scl_fall = ~scl_in & scl_d;
	assign start_c = scl_in & scl_d & sda_d & ~sda_in;
	assign stop_c = scl_in & scl_d & ~sda_d & sda_in;
	assign sda_out = 1'b0;
	assign sda_oe_out = sda_drive;

	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			bs <= BS_IDLE;
			bitn <= 4'h0;
			shreg <= 8'h00;
			rw <= 1'b0;
			bytei <= 2'd0;
			regaddr <= 8'h00;
			txbyte <= 8'hff;
			sda_drive <= 1'b0;
			pend_wr <= 1'b0;
			wdata <= 8'h00;
			vset <= `PGT_RST_VSET;
			config_reg <= `PGT_RST_CONFIG;
		end else begin
			scl_d <= scl_in;
			sda_d <= sda_in;
			if (start_c) begin
				bs <= BS_ADDR;
				bitn <= 4'h0;
				bytei <= 2'd0;
				sda_drive <= 1'b0;
			end else if (stop_c) begin
				bs <= BS_IDLE;
				sda_drive <= 1'b0;
			end else begin
				case (bs)
					BS_ADDR, BS_DATA: begin
						if (scl_rise && !(bs == BS_DATA && rw)) begin
							shreg <= {shreg[6:0], sda_in};
							bitn <= bitn + 4'h1;
						end else if (scl_rise) begin
							bitn <= bitn + 4'h1;
						end
						if (scl_fall && bs == BS_DATA && rw)
							sda_drive <= ~txbyte[7 - bitn[2:0]];
						if (scl_fall && bitn == 4'h8) begin
							bitn <= 4'h8;
							if (bs == BS_ADDR) begin
								rw <= shreg[0];
								if (shreg[7:1] == `PGT_SLAVE_ADDR) begin
									sda_drive <= 1'b1;
									bs <= BS_ACK;
									txbyte <= rd_mux;
								end else
									bs <= BS_IDLE;
							end else if (rw) begin
								sda_drive <= 1'b0;
								bs <= BS_ACK;
							end else begin
								sda_drive <= 1'b1;
								bs <= BS_ACK;
								// byte 0 was the device address, byte 1 is the register pointer
								if (bytei == 2'd1)
									regaddr <= shreg;
								else begin
									wdata <= shreg;
									pend_wr <= 1'b1;
								end
							end
						end
					end
					BS_ACK: begin
						if (scl_rise && rw && sda_in)
							bs <= BS_IDLE; // master nack ends a read
						if (scl_fall) begin
							bitn <= 4'h0;
							bs <= BS_DATA;
							sda_drive <= 1'b0;
							if (rw) begin
								txbyte <= rd_mux;
								sda_drive <= ~rd_mux[7];
								regaddr <= regaddr + 8'h01;
							end else if (bytei != 2'd0 && pend_wr)
								regaddr <= regaddr + 8'h01;
							if (bytei != 2'd3)
								bytei <= bytei + 2'd1;
							pend_wr <= 1'b0;
							if (pend_wr) begin
								// only target and ramp are writable, the rest is fixed
								if (regaddr == `PGT_REG_VSET)
									vset <= wdata;
								else if (regaddr == `PGT_REG_CONFIG)
									config_reg <= {5'h00, wdata[`PGT_SS_MSB:`PGT_SS_LSB]};
							end
						end
					end
					default: bs <= BS_IDLE;
				endcase
			end
		end
	end
endmodule // pgt_top

/* File: design/pgt_defines.vh */
// constants for the power-good telemetry latch block
`ifndef PGT_DEFINES_VH
`define PGT_DEFINES_VH
`define PGT_SLAVE_ADDR 7'h30
`define PGT_REG_VSET 8'h00
`define PGT_REG_CONFIG 8'h03
`define PGT_REG_VOUT_LSB 8'h42
`define PGT_REG_VOUT_MSB 8'h43
`define PGT_REG_VIN 8'h46
`define PGT_REG_IOUT 8'h48
`define PGT_REG_TEMP_LSB 8'h4a
`define PGT_REG_TEMP_MSB 8'h4b
`define PGT_RST_VSET 8'h46
`define PGT_RST_CONFIG 8'h04
`define PGT_UNMAPPED 8'hff
`define PGT_SS_LSB 0
`define PGT_SS_MSB 2
`define PGT_SS_BASE_CYCLES 16'h0040
`define PGT_TEMP_CONV_MS 4
`define PGT_CLK_KHZ 40000
`define PGT_TEMP_CONV_CYCLES (`PGT_TEMP_CONV_MS * `PGT_CLK_KHZ)
`endif

/* File: design/pgt_window.v */
// window comparator: is a measured value inside target plus or minus a percentage
`timescale 1ns/1ps
module pgt_window #(
	parameter W = 16,
	parameter PCT = 5
) (
	// values
	input wire [W-1:0] target_in,
	input wire [W-1:0] value_in,
	// result
	output wire inside_out
);
	// scale by 100 instead of dividing; wide enough to never overflow
	localparam [W+7:0] K_MID = 100;
	localparam [W+7:0] K_LO = 100 - PCT;
	localparam [W+7:0] K_HI = 100 + PCT;
	wire [W+7:0] v100;
	wire [W+7:0] lo;
	wire [W+7:0] hi;
	assign v100 = {8'h00, value_in} * K_MID;
	assign lo = {8'h00, target_in} * K_LO;
	assign hi = {8'h00, target_in} * K_HI;
	assign inside_out = (v100 >= lo) && (v100 <= hi);
endmodule // pgt_window

/* File: sim/pgt_properties.sv */
// port assertions for the power-good telemetry block
`timescale 1ns/1ps
module pgt_properties (
	// clock, reset and watched ports
	input wire clk_sys_in,
	input wire sys_rst_in,
	input wire remote_enable_in,
	input wire input_lockout_upper_threshold_in,
	input wire fault_in,
	input wire [7:0] vout_meas_in,
	input wire output_ok_flag_oe_out,
	input wire soft_start_done_out
);
	// target stays at its reset value 0x46, the bench never rewrites it
	wire act = remote_enable_in && input_lockout_upper_threshold_in;
	wire oe = output_ok_flag_oe_out;
	wire dn = soft_start_done_out;
	wire ok = act && dn && !fault_in;
	wire [7:0] v = vout_meas_in;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_up2;
		act ##1 act;
	endsequence
	AST_SS: assert property (s_up2 ##0 !dn |-> oe) else $error("flag up in ramp");
	AST_OFF: assert property (!act ##1 !act |-> !oe) else $error("flag driven off");
	AST_IN: assert property (s_up2 ##0 (ok && v == 8'h46) |=> !oe) else $error("flag not good");
	AST_HYS: assert property (s_up2 ##0 (ok && !oe && v == 8'h4b) |=> !oe) else $error("flag dropped");
	AST_OUT: assert property (act && (v < 8'h3c || v > 8'h50) |=> oe) else $error("flag kept");
	AST_FLT: assert property (act && fault_in |=> oe) else $error("flag up in fault");
	AST_DN: assert property (!act |=> !dn) else $error("ramp kept off");
	AST_RISE: assert property ($rose(dn) |-> $past(act)) else $error("ramp done off");
endmodule // pgt_properties
bind pgt_top pgt_properties u_chk (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
	.remote_enable_in(remote_enable_in), .input_lockout_upper_threshold_in(input_lockout_upper_threshold_in),
	.fault_in(fault_in), .vout_meas_in(vout_meas_in), .output_ok_flag_oe_out(output_ok_flag_oe_out),
	.soft_start_done_out(soft_start_done_out));

/* File: sim/pgt_i2c_master.sv */
// bus master model: drives the clock and pulls data low
`timescale 1ns/1ps
module pgt_i2c_master (
	// bus lines
	input wire clk_in,
	input wire sda_in,
	output reg scl_out = 1'b1,
	output reg pull_out = 1'b0
);
	// four clocks a phase, as the slave samples its pins with no filter
	task ph;
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	// s low: start or restart, s high: stop
	task cond(input s);
		pull_out = s;
		ph;
		scl_out = 1'b1;
		ph;
		pull_out = !s;
		ph;
		if (!s) begin
			scl_out = 1'b0;
			ph;
		end
	endtask
	// a one releases the line to its pull-up
	task xb(input [7:0] d, input a, output [7:0] q, output k);
		logic [8:0] t;
		t = {d, a};
		for (int i = 8; i >= 0; i--) begin
			pull_out = !t[i];
			ph;
			scl_out = 1'b1;
			ph;
			t[i] = sda_in;
			scl_out = 1'b0;
			ph;
		end
		{q, k} = t;
	endtask
endmodule // pgt_i2c_master

/* File: sim/tb.sv */
// self-checking bench for the power-good telemetry block
`timescale 1ns/1ps
module tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg en = 1'b1;
	reg uvh = 1'b0;
	reg flt = 1'b0;
	reg av = 1'b0;
	reg [7:0] vm = 8'h46;
	reg [1:0] ac = 2'h0;
	reg [15:0] ad = 16'h0;
	reg [7:0] q;
	reg k;
	int error_cnt = 0;
	int checks = 0;
	int n;
	wire scl, pl, so, fo, dn, sdo, fp, tcs;
	localparam int TCONV = 50;
	localparam int SSB = 4;
	wire sda = !(pl || so);
	initial forever #12.5 clk = !clk;
	pgt_i2c_master m (.clk_in(clk), .sda_in(sda), .scl_out(scl), .pull_out(pl));
	pgt_top #(.TEMP_CONV_CYCLES(TCONV), .SS_BASE_CYCLES(SSB)) u_pgt_top (.clk_sys_in(clk), .sys_rst_in(rst),
		.remote_enable_in(en), .input_lockout_upper_threshold_in(uvh), .fault_in(flt), .vout_meas_in(vm),
		.adc_valid_in(av), .adc_chan_in(ac), .adc_data_in(ad), .scl_in(scl), .sda_in(sda), .sda_oe_out(so),
		.sda_out(sdo), .output_ok_flag_out(fp), .output_ok_flag_oe_out(fo), .soft_start_done_out(dn),
		.temp_conv_start_out(tcs));
	task chk(input string w, input [7:0] e, input [7:0] s);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", w, e, s);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task cy(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	// w high writes e, w low reads and expects e; a write checks its data ack
	task tx(input w, input [7:0] r, input [7:0] e);
		m.cond(1'b0);
		m.xb(8'h60, 1'b1, q, k);
		m.xb(r, 1'b1, q, k);
		if (!w) begin
			m.cond(1'b0);
			m.xb(8'h61, 1'b1, q, k);
		end
		m.xb(w ? e : 8'hff, 1'b1, q, k);
		m.cond(1'b1);
		chk("byte", w ? 8'h0 : e, w ? {7'h0, k} : q);
	endtask
	task fl(input [7:0] v, input f, input e, input x);
		vm = v;
		flt = f;
		en = e;
		cy(3);
		chk("flag", {7'h0, x}, {7'h0, fo});
	endtask
	task ad1(input [1:0] c, input [15:0] d);
		ac = c;
		ad = d;
		av = 1'b1;
		cy(1);
		av = 1'b0;
		cy(1);
	endtask
	task t_ramp;
		fl(8'h46, 1'b0, 1'b1, 1'b0);
		for (int i = 0; i < 8; i++) begin
			en = 1'b0;
			uvh = 1'b1;
			tx(1'b1, 8'h03, i[7:0]);
			en = 1'b1;
			for (n = 0; dn !== 1'b1 && n < 600; n++)
				cy(1);
			chk("ramp", 8'h1, {7'h0, n >= (SSB << i) && n <= (SSB << i) + 3});
			if (n == 600)
				report_and_stop;
			fl(8'h46, 1'b0, 1'b1, 1'b0);
		end
		$display("ramp test done");
	endtask
	task t_hys;
		fl(8'h4b, 1'b0, 1'b1, 1'b0);
		fl(8'h51, 1'b0, 1'b1, 1'b1);
		fl(8'h4b, 1'b0, 1'b1, 1'b1);
		fl(8'h46, 1'b0, 1'b1, 1'b0);
		fl(8'h46, 1'b1, 1'b1, 1'b1);
		fl(8'h46, 1'b0, 1'b0, 1'b0);
		chk("done", 8'h0, {7'h0, dn});
		fl(8'h46, 1'b0, 1'b1, 1'b1);
		$display("flag test done");
	endtask
	task t_tel;
		ad1(2'h0, 16'h1234);
		tx(1'b0, 8'h43, 8'h00);
		tx(1'b0, 8'h42, 8'h34);
		ad1(2'h0, 16'h5678);
		ad1(2'h0, 16'h9abc);
		tx(1'b0, 8'h42, 8'h34);
		tx(1'b0, 8'h43, 8'h12);
		tx(1'b0, 8'h42, 8'hbc);
		ad1(2'h1, 16'h5a5a);
		tx(1'b0, 8'h46, 8'h00);
		tx(1'b0, 8'h46, 8'h5a);
		ad1(2'h2, 16'h7e81);
		tx(1'b0, 8'h48, 8'h00);
		tx(1'b0, 8'h48, 8'h7e);
		ad1(2'h3, 16'h3c5a);
		tx(1'b0, 8'h4b, 8'h00);
		tx(1'b0, 8'h4b, 8'h3c);
		tx(1'b0, 8'h4a, 8'h5a);
		$display("telemetry test done");
	endtask
	task t_bus;
		m.cond(1'b0);
		m.xb(8'h62, 1'b1, q, k);
		m.cond(1'b1);
		chk("nack", 8'h1, {7'h0, k});
		tx(1'b0, 8'h10, 8'hff);
		tx(1'b0, 8'h00, 8'h46);
		tx(1'b1, 8'h03, 8'hff);
		tx(1'b0, 8'h03, 8'h07);
		$display("bus test done");
	endtask
	task t_pins;
		for (n = 0; tcs !== 1'b1 && n < 60; n++)
			cy(1);
		cy(1);
		chk("tconv width", 8'h00, {7'h0, tcs});
		for (n = 1; tcs !== 1'b1 && n < 60; n++)
			cy(1);
		chk("tconv period", TCONV[7:0], n[7:0]);
		chk("flag pin", 8'h00, {7'h0, fp});
		chk("sda pin", 8'h00, {7'h0, sdo});
		$display("pin test done");
	endtask
	initial begin
		cy(20);
		rst = 1'b0;
		t_ramp;
		t_hys;
		t_tel;
		t_bus;
		t_pins;
		report_and_stop;
	end
endmodule // tb
